// ### hw/reset_cause_and_timeout_control.sv
// Reset cause flags, start-up time-out sequencer and register file
`timescale 1ns/1ps

module reset_cause_and_timeout_control
  import reset_cause_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_CYCLES_P = POWERUP_TIMER_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire cfg_t              i_cfg,
  input  wire logic              i_power_on_det,
  input  wire logic              i_brownout_det,
  input  wire logic              i_external_reset_pin_n,
  input  wire logic              i_timer1_osc_input,
  input  wire logic              i_watchdog_timeout,
  input  wire logic              i_sleep_enter,
  input  wire logic              i_wake_event,
  input  wire logic [7:0]        i_wake_flags,
  input  wire avs_req_t          i_avs,
  output logic                   o_avs_waitrequest,
  output logic [AVS_DW-1:0]      o_avs_readdata,
  output logic                   o_core_reset,
  output logic                   o_core_sleeping,
  output logic                   o_brownout_detect_en
);

  if (POWERUP_TIMER_CYCLES_P < 1 || POWERUP_TIMER_CYCLES_P > (1 << CNT_W)) begin : g_chk
    $error("POWERUP_TIMER_CYCLES_P out of counter range");
  end

  localparam logic [CNT_W-1:0] POWERUP_TIMER_LOAD = CNT_W'(POWERUP_TIMER_CYCLES_P - 1);

  state_t st;
  state_t next_st;

  // Crystal modes need the start-up count, except low-power crystal mode while the timer1 input is high
  function automatic logic needs_ost(input osc_mode_t m, input logic t1);
    logic xtal;
    xtal = (m == low_power_crystal_mode) || (m == crystal_osc_mode) ||
           (m == high_speed_crystal_mode);
    return xtal && !((m == low_power_crystal_mode) && t1);
  endfunction

  // Brown-out detection enable from configuration and software bit
  function automatic logic bor_enabled(input logic [1:0] f,
                                       input logic sw, input logic slp);
    logic en;
    en = 1'b1;
    if (f == BOR_OFF) begin
      en = 1'b0;
    end else if (f == BOR_SW) begin
      en = sw;
    end else if (f == BOR_NO_SLEEP) begin
      en = !slp;
    end
    return en;
  endfunction

  // Register values common to every reset other than power-on
  function automatic regs_t reset_regs(input regs_t r);
    regs_t n;
    // Timer0, indirect pointer and working register pass through
    n = r;
    n.program_counter_low      = ZERO_BYTE;
    n.machine_flags_and_bank   = r.machine_flags_and_bank &
                                 ~STAT_BANK_MASK;
    n.port_a_latch             = ZERO_BYTE;
    n.interrupt_control        = r.interrupt_control & INTERRUPT_CONTROL_KEEP;
    n.timer2_count             = ZERO_BYTE;
    n.serial_port_control      = ZERO_BYTE;
    n.capture_compare_control  = ZERO_BYTE;
    n.receive_control          = ZERO_BYTE;
    n.power_control_flags[POWER_CONTROL_FLAGS_ULPWU_BIT] = 1'b0;
    return n;
  endfunction

  // Power-on values; unknown fields keep their present contents
  function automatic regs_t power_on_regs(input regs_t r);
    regs_t n;
    n = r;
    n.program_counter_low      = ZERO_BYTE;
    n.machine_flags_and_bank   = (r.machine_flags_and_bank &
                                  ~(STAT_BANK_MASK | STAT_HW_MASK)) |
                                 STATUS_RST;
    n.interrupt_control        = r.interrupt_control & INTERRUPT_CONTROL_KEEP;
    n.timer1_control           = ZERO_BYTE;
    n.timer2_count             = ZERO_BYTE;
    n.serial_port_control      = ZERO_BYTE;
    n.capture_compare_control  = ZERO_BYTE;
    n.receive_control          = ZERO_BYTE;
    n.power_control_flags      = (r.power_control_flags &
                                  (8'h01 << POWER_CONTROL_FLAGS_BOR_BIT)) |
                                 POWER_CONTROL_FLAGS_RST;
    return n;
  endfunction

  // Register read decode
  function automatic logic [7:0] read_reg(input logic [8:0] idx,
                                          input regs_t r);
    logic [7:0] d;
    d = ZERO_BYTE;
    if (idx == IDX_TIMER0_COUNT) begin
      d = r.timer0_count;
    end else if (idx == IDX_PC_LOW) begin
      d = r.program_counter_low;
    end else if (idx == IDX_MACHINE_FLAGS) begin
      d = r.machine_flags_and_bank;
    end else if (idx == IDX_INDIRECT_PTR) begin
      d = r.indirect_pointer;
    end else if (idx == IDX_PORT_A_LATCH) begin
      d = r.port_a_latch;
    end else if (idx == IDX_INT_CONTROL) begin
      d = r.interrupt_control;
    end else if (idx == IDX_TIMER1_CONTROL) begin
      d = r.timer1_control;
    end else if (idx == IDX_TIMER2_COUNT) begin
      d = r.timer2_count;
    end else if (idx == IDX_SERIAL_CONTROL) begin
      d = r.serial_port_control;
    end else if (idx == IDX_CAPCMP_CONTROL) begin
      d = r.capture_compare_control;
    end else if (idx == IDX_RECV_CONTROL) begin
      d = r.receive_control;
    end else if (idx == IDX_POWER_CONTROL) begin
      d = r.power_control_flags & POWER_CONTROL_FLAGS_IMPL_MASK;
    end else if (idx == IDX_WORKING) begin
      d = r.working;
    end
    return d;
  endfunction

  // Register write decode; time-out and power-down are read only
  function automatic regs_t write_reg(input logic [8:0] idx,
                                      input logic [7:0] d,
                                      input regs_t r);
    regs_t n;
    n = r;
    if (idx == IDX_TIMER0_COUNT) begin
      n.timer0_count = d;
    end else if (idx == IDX_PC_LOW) begin
      n.program_counter_low = d;
    end else if (idx == IDX_MACHINE_FLAGS) begin
      n.machine_flags_and_bank = (d & ~STAT_HW_MASK) |
                                 (r.machine_flags_and_bank &
                                  STAT_HW_MASK);
    end else if (idx == IDX_INDIRECT_PTR) begin
      n.indirect_pointer = d;
    end else if (idx == IDX_PORT_A_LATCH) begin
      n.port_a_latch = d;
    end else if (idx == IDX_INT_CONTROL) begin
      n.interrupt_control = d;
    end else if (idx == IDX_TIMER1_CONTROL) begin
      n.timer1_control = d;
    end else if (idx == IDX_TIMER2_COUNT) begin
      n.timer2_count = d;
    end else if (idx == IDX_SERIAL_CONTROL) begin
      n.serial_port_control = d;
    end else if (idx == IDX_CAPCMP_CONTROL) begin
      n.capture_compare_control = d;
    end else if (idx == IDX_RECV_CONTROL) begin
      n.receive_control = d;
    end else if (idx == IDX_POWER_CONTROL) begin
      n.power_control_flags = d & POWER_CONTROL_FLAGS_IMPL_MASK;
    end else if (idx == IDX_WORKING) begin
      n.working = d;
    end
    return n;
  endfunction

  logic       req;
  logic [8:0] idx;
  logic       bor_act;
  logic       pin_rst;
  logic       wdt_rst;
  logic       ost_t;
  logic       wake_ost;

  always_comb begin
    next_st = st;
    // Two-stage synchronisers for pins and analog detectors
    next_st.por_s1 = i_power_on_det;
    next_st.por_s2 = st.por_s1;
    next_st.bor_s1 = i_brownout_det;
    next_st.bor_s2 = st.bor_s1;
    next_st.pin_s1 = i_external_reset_pin_n;
    next_st.pin_s2 = st.pin_s1;
    next_st.t1_s1  = i_timer1_osc_input;
    next_st.t1_s2  = st.t1_s1;

    req      = i_avs.read || i_avs.write;
    idx      = i_avs.address[AVS_AW-1:2];
    pin_rst  = !st.pin_s2;
    wdt_rst  = 1'b0;
    wake_ost = needs_ost(i_cfg.osc_mode, st.t1_s2);
    ost_t    = wake_ost;
    next_st.bor_det_en = bor_enabled(i_cfg.brownout_enable_cfg,
                 st.regs.power_control_flags[POWER_CONTROL_FLAGS_SWBOR_BIT],
                 st.seq == S_SLEEP);
    bor_act  = st.bor_s2 && st.bor_det_en;

    // Avalon slave: one wait cycle, then the transfer is taken
    next_st.avs_wait = !(req && st.avs_wait);
    if (i_avs.read && st.avs_wait) begin
      next_st.rdata = {24'h000000, read_reg(idx, st.regs)};
    end
    if (i_avs.write && !st.avs_wait && i_avs.byteenable[0]) begin
      next_st.regs = write_reg(idx, i_avs.writedata[7:0], st.regs);
    end

    // Hardware updates come after the bus write so a set wins
    if (st.por_s2) begin
      next_st.regs  = power_on_regs(next_st.regs);
      next_st.seq   = S_HOLD;
      next_st.count = POWERUP_TIMER_LOAD;
    end else if (bor_act) begin
      next_st.regs = reset_regs(next_st.regs);
      next_st.regs.power_control_flags[POWER_CONTROL_FLAGS_BOR_BIT]   = 1'b0;
      next_st.regs.machine_flags_and_bank[STAT_TO_BIT] = 1'b1;
      next_st.regs.machine_flags_and_bank[STAT_PD_BIT] = 1'b1;
      next_st.seq   = S_HOLD;
      next_st.count = POWERUP_TIMER_LOAD;
    end else begin
      // Start-up sequencer and run or sleep handling
      case (st.seq)
        S_HOLD: begin
          if (!i_cfg.powerup_timer_disable_cfg) begin
            next_st.seq   = S_POWERUP_TIMER;
            next_st.count = POWERUP_TIMER_LOAD;
          end else if (ost_t) begin
            next_st.seq   = S_OST;
            next_st.count = OST_LOAD;
          end else begin
            next_st.seq = S_RUN;
          end
        end
        S_POWERUP_TIMER: begin
          if (st.count == '0) begin
            if (ost_t) begin
              next_st.seq   = S_OST;
              next_st.count = OST_LOAD;
            end else begin
              next_st.seq = S_RUN;
            end
          end else begin
            next_st.count = st.count - 1'b1;
          end
        end
        S_OST: begin
          if (st.count == '0) begin
            next_st.seq = S_RUN;
          end else begin
            next_st.count = st.count - 1'b1;
          end
        end
        S_RUN: begin
          if (pin_rst) begin
            next_st.regs = reset_regs(next_st.regs);
          end else if (i_watchdog_timeout) begin
            wdt_rst = 1'b1;
            next_st.regs = reset_regs(next_st.regs);
            next_st.regs.machine_flags_and_bank[STAT_TO_BIT] = 1'b0;
          end else if (i_sleep_enter) begin
            next_st.seq = S_SLEEP;
            next_st.regs.machine_flags_and_bank[STAT_TO_BIT] = 1'b1;
            next_st.regs.machine_flags_and_bank[STAT_PD_BIT] = 1'b0;
          end
        end
        S_SLEEP, S_WAKE: begin
          if (pin_rst) begin
            next_st.regs = reset_regs(next_st.regs);
            next_st.regs.machine_flags_and_bank[STAT_TO_BIT] = 1'b1;
            next_st.regs.machine_flags_and_bank[STAT_PD_BIT] = 1'b0;
            next_st.seq = S_RUN;
          end else if (st.seq == S_WAKE) begin
            if (st.count == '0) begin
              next_st.seq = S_RUN;
            end else begin
              next_st.count = st.count - 1'b1;
            end
          end else if (i_watchdog_timeout || i_wake_event) begin
            if (i_watchdog_timeout) begin
              next_st.regs.machine_flags_and_bank[STAT_TO_BIT] = 1'b0;
            end
            next_st.regs.machine_flags_and_bank[STAT_PD_BIT] = 1'b0;
            // Only an interrupt wake marks its cause flags
            if (i_wake_event) begin
              next_st.regs.interrupt_control =
                next_st.regs.interrupt_control | i_wake_flags;
            end
            if (i_wake_event &&
                st.regs.interrupt_control[INTERRUPT_CONTROL_GIE_BIT]) begin
              next_st.regs.program_counter_low = WAKE_VECTOR;
            end else begin
              next_st.regs.program_counter_low =
                st.regs.program_counter_low + 8'h01;
            end
            if (wake_ost) begin
              next_st.seq   = S_WAKE;
              next_st.count = OST_LOAD;
            end else begin
              next_st.seq = S_RUN;
            end
          end
        end
        default: begin
          next_st.seq = S_HOLD;
        end
      endcase
    end

    // Core held in reset while any reset cause is active and through hold, power-up timer and OST; the wake time-out shows as sleeping
    next_st.core_reset = st.por_s2 || bor_act || pin_rst || wdt_rst ||
                         (next_st.seq == S_HOLD) ||
                         (next_st.seq == S_POWERUP_TIMER) ||
                         (next_st.seq == S_OST);
    next_st.sleeping   = (next_st.seq == S_SLEEP) ||
                         (next_st.seq == S_WAKE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st                                   <= '0;
      st.seq                               <= S_HOLD;
      st.count                             <= POWERUP_TIMER_LOAD;
      st.avs_wait                          <= 1'b1;
      st.core_reset                        <= 1'b1;
      st.pin_s1                            <= 1'b1;
      st.pin_s2                            <= 1'b1;
      st.regs.machine_flags_and_bank       <= STATUS_RST;
      st.regs.power_control_flags          <= POWER_CONTROL_FLAGS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_avs_waitrequest    = st.avs_wait;
  assign o_avs_readdata       = st.rdata;
  assign o_core_reset         = st.core_reset;
  assign o_core_sleeping      = st.sleeping;
  assign o_brownout_detect_en = st.bor_det_en;

endmodule // reset_cause_and_timeout_control

// ### hw/reset_cause_pkg.sv
// Constants, types and register map of the reset cause and time-out block
package reset_cause_pkg;

  // Clock and time-outs
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned POWERUP_TIMER_TIME_MS = 64;
  localparam int unsigned POWERUP_TIMER_CYCLES  = POWERUP_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_PERIODS  = 1024;
  localparam int unsigned OST_CYCLES   = OST_PERIODS;
  localparam int unsigned CNT_W        = 24;
  localparam logic [CNT_W-1:0] OST_LOAD = CNT_W'(OST_CYCLES - 1);

  // Avalon-MM shape
  localparam int unsigned AVS_AW = 11;
  localparam int unsigned AVS_DW = 32;

  // Register indices, byte address is four times the index
  localparam logic [8:0] IDX_TIMER0_COUNT   = 9'h001;
  localparam logic [8:0] IDX_PC_LOW         = 9'h002;
  localparam logic [8:0] IDX_MACHINE_FLAGS  = 9'h003;
  localparam logic [8:0] IDX_INDIRECT_PTR   = 9'h004;
  localparam logic [8:0] IDX_PORT_A_LATCH   = 9'h005;
  localparam logic [8:0] IDX_INT_CONTROL    = 9'h00B;
  localparam logic [8:0] IDX_TIMER1_CONTROL = 9'h010;
  localparam logic [8:0] IDX_TIMER2_COUNT   = 9'h011;
  localparam logic [8:0] IDX_SERIAL_CONTROL = 9'h014;
  localparam logic [8:0] IDX_CAPCMP_CONTROL = 9'h017;
  localparam logic [8:0] IDX_RECV_CONTROL   = 9'h018;
  localparam logic [8:0] IDX_POWER_CONTROL  = 9'h08E;
  localparam logic [8:0] IDX_WORKING        = 9'h100;

  // Field positions
  localparam int unsigned POWER_CONTROL_FLAGS_ULPWU_BIT  = 5;
  localparam int unsigned POWER_CONTROL_FLAGS_SWBOR_BIT  = 4;
  localparam int unsigned POWER_CONTROL_FLAGS_POR_BIT    = 1;
  localparam int unsigned POWER_CONTROL_FLAGS_BOR_BIT    = 0;
  localparam int unsigned STAT_TO_BIT     = 4;
  localparam int unsigned STAT_PD_BIT     = 3;
  localparam int unsigned INTERRUPT_CONTROL_GIE_BIT  = 7;
  localparam logic [7:0]  POWER_CONTROL_FLAGS_IMPL_MASK  = 8'h33;
  localparam logic [7:0]  STAT_BANK_MASK  = 8'hE0;
  localparam logic [7:0]  STAT_HW_MASK    = 8'h18;
  localparam logic [7:0]  INTERRUPT_CONTROL_KEEP     = 8'h01;

  // Values after reset and the interrupt wake vector
  localparam logic [7:0] STATUS_RST    = 8'h18;
  localparam logic [7:0] POWER_CONTROL_FLAGS_RST      = 8'h10;
  localparam logic [7:0] WAKE_VECTOR   = 8'h04;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // Brown-out enable field
  localparam logic [1:0] BOR_OFF       = 2'h0;
  localparam logic [1:0] BOR_SW        = 2'h1;
  localparam logic [1:0] BOR_NO_SLEEP  = 2'h2;

  typedef enum logic [2:0] {
    low_power_crystal_mode      = 3'h0,
    crystal_osc_mode            = 3'h1,
    high_speed_crystal_mode     = 3'h2,
    resistor_capacitor_osc_mode = 3'h3,
    external_clock_mode         = 3'h4,
    internal_osc_mode           = 3'h5
  } osc_mode_t;

  typedef enum logic [5:0] {
    S_HOLD  = 6'h01,
    S_POWERUP_TIMER  = 6'h02,
    S_OST   = 6'h04,
    S_RUN   = 6'h08,
    S_SLEEP = 6'h10,
    S_WAKE  = 6'h20
  } seq_state_t;

  typedef struct packed {
    osc_mode_t  osc_mode;
    logic       powerup_timer_disable_cfg;
    logic [1:0] brownout_enable_cfg;
  } cfg_t;

  typedef struct packed {
    logic [AVS_AW-1:0] address;
    logic              read;
    logic              write;
    logic [AVS_DW-1:0] writedata;
    logic [3:0]        byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] timer0_count;
    logic [7:0] program_counter_low;
    logic [7:0] machine_flags_and_bank;
    logic [7:0] indirect_pointer;
    logic [7:0] port_a_latch;
    logic [7:0] interrupt_control;
    logic [7:0] timer1_control;
    logic [7:0] timer2_count;
    logic [7:0] serial_port_control;
    logic [7:0] capture_compare_control;
    logic [7:0] receive_control;
    logic [7:0] power_control_flags;
  } regs_t;

  typedef struct packed {
    seq_state_t        seq;
    logic [CNT_W-1:0]  count;
    regs_t             regs;
    logic              avs_wait;
    logic [AVS_DW-1:0] rdata;
    logic              core_reset;
    logic              sleeping;
    logic              bor_det_en;
    logic              por_s1;
    logic              por_s2;
    logic              bor_s1;
    logic              bor_s2;
    logic              pin_s1;
    logic              pin_s2;
    logic              t1_s1;
    logic              t1_s2;
  } state_t;

endpackage

// ### test/reset_cause_properties.sv
// Port-level properties of the reset cause and time-out block
`timescale 1ns/1ps
module reset_cause_properties
  import reset_cause_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_rstn,
  input wire cfg_t              i_cfg,
  input wire logic              i_power_on_det,
  input wire logic              i_brownout_det,
  input wire logic              i_external_reset_pin_n,
  input wire logic              i_watchdog_timeout,
  input wire logic              i_wake_event,
  input wire avs_req_t          i_avs,
  input wire logic              o_avs_waitrequest,
  input wire logic [AVS_DW-1:0] o_avs_readdata,
  input wire logic              o_core_reset,
  input wire logic              o_core_sleeping,
  input wire logic              o_brownout_detect_en
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire logic rd_pc = i_avs.read && i_avs.address == {IDX_POWER_CONTROL, 2'b00};
  property p_one_wait;
    $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
  endproperty
  property p_rest;
    !(i_avs.read || i_avs.write) |-> o_avs_waitrequest;
  endproperty
  property p_power_control_flags_gap;
    rd_pc && !o_avs_waitrequest |-> (o_avs_readdata & 32'hFFFFFFCC) == 32'h0;
  endproperty
  property p_wdt_run;
    i_watchdog_timeout && !o_core_reset && !o_core_sleeping |=> o_core_reset;
  endproperty
  property p_por_hold;
    i_power_on_det [*4] |-> o_core_reset;
  endproperty
  property p_pin_hold;
    !i_external_reset_pin_n [*4] |-> o_core_reset;
  endproperty
  property p_bor_hold;
    (i_brownout_det && o_brownout_detect_en) [*4] |-> o_core_reset;
  endproperty
  property p_bor_off;
    (i_cfg.brownout_enable_cfg == BOR_OFF) [*2] |-> !o_brownout_detect_en;
  endproperty
  property p_wake_xt;
    i_wake_event && o_core_sleeping && i_cfg.osc_mode == crystal_osc_mode
      |=> o_core_sleeping [*8];
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  a_rest: assert property (p_rest) else $error("wait low at rest");
  a_power_control_flags_gap: assert property (p_power_control_flags_gap)
    else $error("unused bits set");
  a_wdt_run: assert property (p_wdt_run)
    else $error("no watchdog reset");
  a_por_hold: assert property (p_por_hold)
    else $error("no power-on hold");
  a_pin_hold: assert property (p_pin_hold)
    else $error("no pin hold");
  a_bor_hold: assert property (p_bor_hold)
    else $error("no brown-out hold");
  a_bor_off: assert property (p_bor_off)
    else $error("detector on when off");
  a_wake_xt: assert property (p_wake_xt)
    else $error("wake delay short");
  c_wake: cover property (i_wake_event && o_core_sleeping);
  c_power_control_flags: cover property (rd_pc && !o_avs_waitrequest);
  c_wdt: cover property (i_watchdog_timeout && o_core_sleeping);
endmodule // reset_cause_properties

bind reset_cause_and_timeout_control reset_cause_properties i_props (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cfg(i_cfg),
  .i_power_on_det(i_power_on_det), .i_brownout_det(i_brownout_det),
  .i_external_reset_pin_n(i_external_reset_pin_n),
  .i_watchdog_timeout(i_watchdog_timeout), .i_wake_event(i_wake_event),
  .i_avs(i_avs), .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_readdata(o_avs_readdata), .o_core_reset(o_core_reset),
  .o_core_sleeping(o_core_sleeping),
  .o_brownout_detect_en(o_brownout_detect_en));

// ### test/reset_cause_and_timeout_control_tb.sv
// Self-checking bench for the reset cause and time-out block
`timescale 1ns/1ps
module reset_cause_and_timeout_control_tb;
  import reset_cause_pkg::*;
  localparam int PW = 20;
  logic        i_sys_clk, i_rstn, i_power_on_det, i_brownout_det;
  logic        i_external_reset_pin_n, i_watchdog_timeout;
  logic        i_sleep_enter, i_wake_event, i_timer1_osc_input;
  logic        o_avs_waitrequest, o_core_reset, o_core_sleeping, o_bor_en;
  logic [7:0]  i_wake_flags, rd, v;
  logic [31:0] o_avs_readdata;
  cfg_t        i_cfg;
  avs_req_t    i_avs;
  int          fails, checks_done, seed, n;
  logic [7:0]  m [13];
  logic [8:0]  ix [13] = '{IDX_WORKING, IDX_TIMER0_COUNT, IDX_PC_LOW,
    IDX_MACHINE_FLAGS, IDX_INDIRECT_PTR, IDX_PORT_A_LATCH, IDX_INT_CONTROL,
    IDX_TIMER1_CONTROL, IDX_TIMER2_COUNT, IDX_SERIAL_CONTROL,
    IDX_CAPCMP_CONTROL, IDX_RECV_CONTROL, IDX_POWER_CONTROL};
  int          rk [13] = '{0, 0, 1, 0, 0, 4, 2, 3, 1, 1, 1, 1, 0};
  int          sk [8] = '{0, 1, 2, 3, 0, 1, 4, 4};

  reset_cause_and_timeout_control #(.POWERUP_TIMER_CYCLES_P(PW)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cfg(i_cfg),
    .i_power_on_det(i_power_on_det), .i_brownout_det(i_brownout_det),
    .i_external_reset_pin_n(i_external_reset_pin_n),
    .i_timer1_osc_input(i_timer1_osc_input),
    .i_watchdog_timeout(i_watchdog_timeout),
    .i_sleep_enter(i_sleep_enter), .i_wake_event(i_wake_event),
    .i_wake_flags(i_wake_flags), .i_avs(i_avs),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
    .o_core_reset(o_core_reset), .o_core_sleeping(o_core_sleeping),
    .o_brownout_detect_en(o_bor_en));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      fails++;
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_avs <= '{{a, 2'b00}, !w, w, {24'h0, d}, 4'hF};
    for (n = 0; n < 50 && (n == 0 || o_avs_waitrequest); n++)
      @(posedge i_sys_clk);
    if (n == 50) begin
      fails++;
      wrap_up();
    end
    rd = o_avs_readdata[7:0];
    i_avs.read <= 1'b0;
    i_avs.write <= 1'b0;
  endtask

  task automatic wait_run;
    repeat (6) @(posedge i_sys_clk);
    for (n = 0; n < 4000 && (o_core_reset || o_core_sleeping); n++)
      @(posedge i_sys_clk);
    if (n == 4000) begin
      fails++;
      wrap_up();
    end
  endtask

  // Model of register contents after a reset
  task automatic rst_m(input logic por);
    for (int i = 0; i < 13; i++)
      case (rk[i])
        1: m[i] = 8'h00;
        2: m[i] &= 8'h01;
        3: if (por) m[i] = 8'h00;
        4: if (!por) m[i] = 8'h00;
        default: ;
      endcase
  endtask

  task automatic check_all;
    logic [7:0] k;
    for (int i = 0; i < 13; i++) begin
      k = (i == 3) ? 8'h18 : (i == 12) ? 8'h03 : 8'hFF;
      bus(1'b0, ix[i], 8'h00);
      check(rd & k, m[i] & k);
    end
  endtask

  task automatic fill(input logic gie);
    for (int i = 0; i < 12; i++)
      if (i != 2) begin
        v = 8'($random(seed)) & ((i == 6) ? 8'h7F : 8'hFF);
        if (i == 6 && gie) v[7] = 1'b1;
        bus(1'b1, ix[i], v);
        if (i != 3) m[i] = v;
      end
    bus(1'b1, IDX_POWER_CONTROL, 8'h13);
    m[12][1:0] = 2'b11;
  endtask

  task automatic lvl(input int k, input logic on);
    case (k)
      0: i_watchdog_timeout <= on;
      1: i_external_reset_pin_n <= !on;
      2: i_brownout_det <= on;
      3: i_power_on_det <= on;
      default: i_wake_event <= on;
    endcase
  endtask

  initial begin
    seed = 32'hEC0F0204;
    fails = 0;
    checks_done = 0;
    {i_rstn, i_power_on_det, i_brownout_det, i_watchdog_timeout} = 4'h0;
    {i_sleep_enter, i_wake_event, i_external_reset_pin_n} = 3'h1;
    i_timer1_osc_input = 1'b0;
    i_cfg = '{crystal_osc_mode, 1'b0, BOR_SW};
    i_avs = '0;
    i_wake_flags = 8'h00;
    foreach (m[i]) m[i] = 8'h00;
    m[3] = 8'h18;
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    for (n = 0; n < 4000 && (n < 3 || o_core_reset); n++)
      @(posedge i_sys_clk);
    check(n >= PW + 1024 && n <= PW + 1032, 1);
    check_all;
    bus(1'b1, IDX_POWER_CONTROL, 8'hFF);
    bus(1'b0, IDX_POWER_CONTROL, 8'h00);
    check(rd, 8'h33);
    bus(1'b1, 9'h1FF, 8'hA5);
    bus(1'b0, 9'h1FF, 8'h00);
    check(rd, 8'h00);
    for (int ev = 0; ev < 8; ev++) begin
      fill(ev == 7);
      if (ev >= 4) begin
        i_sleep_enter <= 1'b1;
        @(posedge i_sys_clk);
        i_sleep_enter <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        m[3][4:3] = 2'b10;
      end
      v = 8'($random(seed)) & 8'h7F;
      i_wake_flags <= v;
      lvl(sk[ev], 1'b1);
      repeat ((sk[ev] % 4 == 0) ? 1 : 5) @(posedge i_sys_clk);
      lvl(sk[ev], 1'b0);
      case (ev)
        0: begin
          rst_m(1'b0);
          m[3][4] = 1'b0;
        end
        1: rst_m(1'b0);
        2: begin
          rst_m(1'b0);
          m[12][0] = 1'b0;
          m[3][4:3] = 2'b11;
        end
        3: begin
          rst_m(1'b1);
          m[12][1] = 1'b0;
          m[3][4:3] = 2'b11;
        end
        4: begin
          m[2] = m[2] + 8'h01;
          m[3][4:3] = 2'b00;
        end
        5: rst_m(1'b0);
        default: begin
          m[2] = m[6][7] ? 8'h04 : m[2] + 8'h01;
          m[6] |= v;
        end
      endcase
      wait_run;
      check_all;
    end
    i_cfg.brownout_enable_cfg <= BOR_OFF;
    repeat (3) @(posedge i_sys_clk);
    i_brownout_det <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    check(o_core_reset, 1'b0);
    i_brownout_det <= 1'b0;
    i_timer1_osc_input <= 1'b1;
    for (int md = 0; md < 2; md++) begin
      i_cfg.osc_mode <= md ? resistor_capacitor_osc_mode
                           : low_power_crystal_mode;
      i_cfg.powerup_timer_disable_cfg <= (md == 1);
      repeat (4) @(posedge i_sys_clk);
      lvl(3, 1'b1);
      repeat (5) @(posedge i_sys_clk);
      lvl(3, 1'b0);
      for (n = 0; n < 4000 && (n < 3 || o_core_reset); n++)
        @(posedge i_sys_clk);
      check(md ? (n <= 8) : (n >= PW && n <= PW + 8), 1);
      i_sleep_enter <= 1'b1;
      @(posedge i_sys_clk);
      i_sleep_enter <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      check(o_core_sleeping, 1'b1);
      lvl(4, 1'b1);
      @(posedge i_sys_clk);
      lvl(4, 1'b0);
      repeat (2) @(posedge i_sys_clk);
      check(o_core_sleeping, 1'b0);
    end
    wrap_up;
  end
endmodule // reset_cause_and_timeout_control_tb
